//--- verilog/dbpo_port.sv
`timescale 1ns/1ns
module dbpo_port
	import dbpo_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                hsel,
	input  wire logic [11:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic [WIDTH-1:0]    port_c_in,
	output logic      [WIDTH-1:0]    port_c_out,
	output logic      [WIDTH-1:0]    port_c_oe,
	input  wire logic [WIDTH-1:0]    port_d_in,
	output logic      [WIDTH-1:0]    port_d_out,
	output logic      [WIDTH-1:0]    port_d_oe,
	input  wire logic                port_b_bit3_in,
	input  wire logic                capture2_pin_select,
	input  wire dbpo_pkg::dbpo_periph_t periph,
	output dbpo_pkg::dbpo_fromio_t   fromio
);
	import dbpo_pkg::*;

	// Pin map and read mux are written for eight pins only
	if (WIDTH != 8)
	begin : g_width_check
		$error("dbpo_port supports WIDTH 8 only");
	end

	logic [WIDTH-1:0] port_c_out_register;
	logic [WIDTH-1:0] port_c_direction_register;
	logic [WIDTH-1:0] port_d_out_register;
	logic [WIDTH-1:0] port_d_direction_register;
	logic [7:0]       port_e_direction_register;
	logic [WIDTH-1:0] c_meta;
	logic [WIDTH-1:0] port_c_pin_value;
	logic [WIDTH-1:0] d_meta;
	logic [WIDTH-1:0] port_d_pin_value;
	logic             b3_meta;
	logic             b3_sync;
	logic             dp_write;
	logic [11:0]      dp_addr;
	logic             dp_read;
	logic [31:0]      next_hrdata;

	// Address phase capture, no wait states
	wire addr_take = hsel && hready && htrans[1];
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dp_write <= 1'b0;
			dp_read  <= 1'b0;
			dp_addr  <= 12'h000;
		end
		else
		begin
			dp_write <= addr_take && hwrite;
			dp_read  <= addr_take && !hwrite;
			dp_addr  <= {haddr[11:2], 2'b00};
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Write decode in data phase
	wire wr_c_pin = dp_write && (dp_addr == DBPO_PORT_C_PIN_OFF);
	wire wr_c_out = dp_write && (dp_addr == DBPO_PORT_C_OUT_OFF);
	wire wr_c_dir = dp_write && (dp_addr == DBPO_PORT_C_DIR_OFF);
	wire wr_d_pin = dp_write && (dp_addr == DBPO_PORT_D_PIN_OFF);
	wire wr_d_out = dp_write && (dp_addr == DBPO_PORT_D_OUT_OFF);
	wire wr_d_dir = dp_write && (dp_addr == DBPO_PORT_D_DIR_OFF);
	wire wr_e_dir = dp_write && (dp_addr == DBPO_PORT_E_DIR_OFF);

	// Latches and directions; reset floats all pins
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port_c_out_register       <= DBPO_LAT_RESET;
			port_c_direction_register <= DBPO_DIR_RESET;
			port_d_out_register       <= DBPO_LAT_RESET;
			port_d_direction_register <= DBPO_DIR_RESET;
			port_e_direction_register <= DBPO_PORT_E_RESET;
		end
		else
		begin
			if (wr_c_pin || wr_c_out)
				port_c_out_register <= hwdata[WIDTH-1:0];
			if (wr_c_dir)
				port_c_direction_register <= hwdata[WIDTH-1:0];
			if (wr_d_pin || wr_d_out)
				port_d_out_register <= hwdata[WIDTH-1:0];
			if (wr_d_dir)
				port_d_direction_register <= hwdata[WIDTH-1:0];
			if (wr_e_dir)
				port_e_direction_register <= hwdata[7:0];
		end
	end

	// Pin synchronisers; pins are asynchronous to ref_clk
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			c_meta           <= '0;
			port_c_pin_value <= '0;
			d_meta           <= '0;
			port_d_pin_value <= '0;
			b3_meta          <= 1'b0;
			b3_sync          <= 1'b0;
		end
		else
		begin
			c_meta           <= port_c_in;
			port_c_pin_value <= c_meta;
			d_meta           <= port_d_in;
			port_d_pin_value <= d_meta;
			b3_meta          <= port_b_bit3_in;
			b3_sync          <= b3_meta;
		end
	end

	// Read mux; direction reads ignore overrides
	wire [7:0] rd_sel =
		(dp_addr == DBPO_PORT_C_PIN_OFF) ? port_c_pin_value :
		(dp_addr == DBPO_PORT_C_OUT_OFF) ? port_c_out_register :
		(dp_addr == DBPO_PORT_C_DIR_OFF) ? port_c_direction_register :
		(dp_addr == DBPO_PORT_D_PIN_OFF) ? port_d_pin_value :
		(dp_addr == DBPO_PORT_D_OUT_OFF) ? port_d_out_register :
		(dp_addr == DBPO_PORT_D_DIR_OFF) ? port_d_direction_register :
		(dp_addr == DBPO_PORT_E_DIR_OFF) ? port_e_direction_register :
		8'h00;
	assign next_hrdata = dp_read ? {24'h000000, rd_sel} : 32'h00000000;
	assign hrdata      = next_hrdata;

	// Port C lower pins: plain port behaviour
	wire [3:0] c_low_oe = ~port_c_direction_register[3:0];

	// Bit 4: serial-in relies on software input; two-wire drives low
	wire c4_twi = periph.twi_en && port_c_direction_register[4];
	wire c4_oe  = c4_twi ? periph.twi_sda_drive_low : !port_c_direction_register[4];
	wire c4_out = c4_twi ? 1'b0 : port_c_out_register[4];

	// Bit 5: serial out wins over latch when output
	wire c5_oe  = !port_c_direction_register[5];
	wire c5_out = periph.spi_en ? periph.spi_serial_out : port_c_out_register[5];

	// Bit 6: async transmit, or transmit line as sync master clock
	wire c6_tx  = periph.uart_en && !periph.uart_sync;
	wire c6_clk = periph.uart_en && periph.uart_sync && periph.uart_master;
	wire c6_slv = periph.uart_en && periph.uart_sync && !periph.uart_master;
	wire c6_oe  = c6_tx ? !port_c_direction_register[6] :
		c6_clk ? 1'b1 : c6_slv ? 1'b0 : !port_c_direction_register[6];
	wire c6_out = (c6_tx || c6_clk) ? periph.uart_tx : port_c_out_register[6];

	// Bit 7: sync data drives when transmitting
	wire c7_sync = periph.uart_en && periph.uart_sync;
	wire c7_oe   = c7_sync ? periph.uart_data_drive : !port_c_direction_register[7];
	wire c7_out  = c7_sync ? periph.uart_data_out : port_c_out_register[7];

	// Pin outputs registered from next values
	wire [7:0] next_c_out = {c7_out, c6_out, c5_out, c4_out, port_c_out_register[3:0]};
	wire [7:0] next_c_oe  = {c7_oe, c6_oe, c5_oe, c4_oe, c_low_oe};

	// Port D: parallel slave mode, disabled by multi-output PWM
	wire par_slave_on = port_e_direction_register[DBPO_PAR_SLAVE_BIT]
		&& !periph.pwm_multi;
	wire [7:0] pwm_en  = {periph.pwm_d_en, periph.pwm_c_en, periph.pwm_b_en, 5'h00};
	wire [7:0] pwm_val = {periph.pwm_channel_d, periph.pwm_channel_c, periph.pwm_channel_b, 5'h00};
	wire [7:0] d_base_oe = par_slave_on ? 8'h00 : ~port_d_direction_register;
	wire [7:0] next_d_oe  = (pwm_en & ~port_d_direction_register) | (~pwm_en & d_base_oe);
	wire [7:0] next_d_out = (pwm_en & pwm_val) | (~pwm_en & port_d_out_register);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port_c_out <= '0;
			port_c_oe  <= '0;
			port_d_out <= '0;
			port_d_oe  <= '0;
		end
		else
		begin
			port_c_out <= next_c_out;
			port_c_oe  <= next_c_oe;
			port_d_out <= next_d_out;
			port_d_oe  <= next_d_oe;
		end
	end

	// Inputs back to the units, from synchronised pins
	assign fromio.spi_serial_in       = port_c_pin_value[4];
	assign fromio.twi_sda_in          = port_c_pin_value[4];
	assign fromio.uart_rx             = port_c_direction_register[7] && port_c_pin_value[7];
	assign fromio.sync_serial_clk     = port_c_pin_value[6];
	assign fromio.sync_serial_data    = port_c_pin_value[7];
	assign fromio.capture2_in         = capture2_pin_select ? port_c_pin_value[1] : b3_sync;
	assign fromio.parallel_slave_port = par_slave_on;
	assign fromio.par_slave_data_in   = par_slave_on ? port_d_pin_value : 8'h00;
endmodule : dbpo_port

//--- verilog/dbpo_pkg.sv
package dbpo_pkg;
	localparam logic [11:0] DBPO_PORT_C_PIN_OFF = 12'h000;
	localparam logic [11:0] DBPO_PORT_C_OUT_OFF = 12'h004;
	localparam logic [11:0] DBPO_PORT_C_DIR_OFF = 12'h008;
	localparam logic [11:0] DBPO_PORT_D_PIN_OFF = 12'h00c;
	localparam logic [11:0] DBPO_PORT_D_OUT_OFF = 12'h010;
	localparam logic [11:0] DBPO_PORT_D_DIR_OFF = 12'h014;
	localparam logic [11:0] DBPO_PORT_E_DIR_OFF = 12'h018;
	localparam logic [7:0]  DBPO_DIR_RESET      = 8'hff;
	localparam logic [7:0]  DBPO_LAT_RESET      = 8'h00;
	localparam logic [7:0]  DBPO_PORT_E_RESET   = 8'h07;
	localparam int          DBPO_PAR_SLAVE_BIT  = 4;
	localparam int          DBPO_SYNC_STAGES    = 2;

	// Peripheral requests from the units sharing the pins
	typedef struct packed {
		logic spi_en;
		logic spi_serial_out;
		logic twi_en;
		logic twi_sda_drive_low;
		logic uart_en;
		logic uart_sync;
		logic uart_master;
		logic uart_tx; // Also the master clock in sync mode
		logic uart_data_out;
		logic uart_data_drive;
		logic pwm_multi;
		logic pwm_b_en;
		logic pwm_c_en;
		logic pwm_d_en;
		logic pwm_channel_b;
		logic pwm_channel_c;
		logic pwm_channel_d;
	} dbpo_periph_t;

	// Inputs returned to the units from the pins
	typedef struct packed {
		logic spi_serial_in;
		logic twi_sda_in;
		logic uart_rx;
		logic sync_serial_clk;
		logic sync_serial_data;
		logic capture2_in;
		logic parallel_slave_port;
		logic [7:0] par_slave_data_in;
	} dbpo_fromio_t;
endpackage : dbpo_pkg

//--- sim/dbpo_pins_model.sv
`timescale 1ns/1ns
module dbpo_pins_model (
	input  wire logic [7:0] c_out,
	input  wire logic [7:0] c_oe,
	input  wire logic [7:0] ext_c,
	output logic      [7:0] c_in,
	input  wire logic [7:0] d_out,
	input  wire logic [7:0] d_oe,
	input  wire logic [7:0] ext_d,
	output logic      [7:0] d_in
);
	// Outside drive only where the port lets go, so no fight
	assign c_in = (c_oe & c_out) | (~c_oe & ext_c);
	assign d_in = (d_oe & d_out) | (~d_oe & ext_d);
endmodule : dbpo_pins_model

//--- sim/dbpo_port_properties.sv
`timescale 1ns/1ns
module dbpo_port_properties (
	input wire logic                   ref_clk,
	input wire logic                   rst_n,
	input wire logic [7:0]             port_c_in,
	input wire logic [7:0]             port_c_out,
	input wire logic [7:0]             port_c_oe,
	input wire logic [7:0]             port_d_out,
	input wire logic [7:0]             port_d_oe,
	input wire logic                   port_b_bit3_in,
	input wire logic                   capture2_pin_select,
	input wire dbpo_pkg::dbpo_periph_t periph,
	input wire dbpo_pkg::dbpo_fromio_t fromio
);
	import dbpo_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Overrides judged only once requests settle, pins are registered
	sequence s_calm;
		$stable(periph) [*2];
	endsequence
	property p_reset;
		$rose(rst_n) |-> {port_c_oe, port_d_oe} == 16'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("pin driven");
	property p_twi;
		s_calm ##0 (periph.twi_en && periph.twi_sda_drive_low) |-> port_c_oe[4] && !port_c_out[4];
	endproperty
	a_twi: assert property (p_twi) else $error("twi");
	property p_spi;
		s_calm ##0 (periph.spi_en && port_c_oe[5]) |-> port_c_out[5] == periph.spi_serial_out;
	endproperty
	a_spi: assert property (p_spi) else $error("spi");
	property p_tx;
		s_calm ##0 (periph.uart_en && !periph.uart_sync && port_c_oe[6]) |-> port_c_out[6] == periph.uart_tx;
	endproperty
	a_tx: assert property (p_tx) else $error("tx");
	property p_clk;
		s_calm ##0 (periph.uart_en && periph.uart_sync && periph.uart_master && port_c_oe[6])
			|-> port_c_out[6] == periph.uart_tx;
	endproperty
	a_clk: assert property (p_clk) else $error("clk");
	property p_sync_data;
		s_calm ##0 (periph.uart_en && periph.uart_sync && periph.uart_data_drive && port_c_oe[7])
			|-> port_c_out[7] == periph.uart_data_out;
	endproperty
	a_sync_data: assert property (p_sync_data) else $error("sync data");
	property p_pwm;
		s_calm ##0 (periph.pwm_b_en && port_d_oe[5]) |-> port_d_out[5] == periph.pwm_channel_b;
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm");
	property p_cap;
		$stable({capture2_pin_select, port_c_in[1], port_b_bit3_in}) [*5]
			|-> fromio.capture2_in == (capture2_pin_select ? port_c_in[1] : port_b_bit3_in);
	endproperty
	a_cap: assert property (p_cap) else $error("capture");
endmodule : dbpo_port_properties
bind dbpo_port dbpo_port_properties dbpo_port_properties_inst (.ref_clk, .rst_n, .port_c_in,
	.port_c_out, .port_c_oe, .port_d_out, .port_d_oe, .port_b_bit3_in, .capture2_pin_select,
	.periph, .fromio);

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import dbpo_pkg::*;
	typedef struct packed {logic wr; logic [11:0] wa; logic [7:0] wd; logic [11:0] ra; logic [7:0] ex;} dbpo_row_t;
	logic         ref_clk, rst_n = 0, hwrite = 0, hreadyout, hresp, cap_sel = 1, pb3 = 0;
	logic [11:0]  haddr = 0;
	logic [1:0]   htrans = 0;
	logic [31:0]  hwdata = 0, hrdata, r;
	logic [7:0]   c_in, c_out, c_oe, d_in, d_out, d_oe, ext_c = 8'hd6, ext_d = 8'hc3;
	dbpo_periph_t periph = '0;
	dbpo_fromio_t fromio;
	int           failures = 0, total_checks = 0;
	// Reset values first, then write and read back
	dbpo_row_t    rows [9] = '{'{0, 0, 0, 12'h008, 8'hff}, '{0, 0, 0, 12'h004, 8'h00},
		'{0, 0, 0, 12'h018, 8'h07}, '{1, 12'h008, 8'h0f, 12'h008, 8'h0f},
		'{1, 12'h004, 8'ha5, 12'h004, 8'ha5}, '{1, 12'h000, 8'h3c, 12'h004, 8'h3c},
		'{1, 12'h014, 8'h33, 12'h014, 8'h33}, '{1, 12'h010, 8'h5a, 12'h010, 8'h5a},
		'{1, 12'h01c, 8'hff, 12'h01c, 8'h00}};
	dbpo_port dbpo_port_inst (.ref_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.port_c_in(c_in), .port_c_out(c_out), .port_c_oe(c_oe), .port_d_in(d_in),
		.port_d_out(d_out), .port_d_oe(d_oe), .port_b_bit3_in(pb3),
		.capture2_pin_select(cap_sel), .periph, .fromio);
	dbpo_pins_model dbpo_pins_model_inst (.c_out, .c_oe, .ext_c, .c_in, .d_out, .d_oe, .ext_d, .d_in);
	initial
	begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// Ready and read data both taken at the rising edge that ends the phase
	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		r = hrdata;
		if (hreadyout !== 1'b1)
		begin
			failures++;
			final_report();
		end
	endtask : wait_ready
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
	endtask : xfer
	task rd(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h0);
		chk(r, 32'(e));
	endtask : rd
	task settle;
		repeat (4) @(posedge ref_clk);
	endtask : settle
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk(32'({hresp, c_oe, d_oe}), 32'h0);
		foreach (rows[i])
		begin
			if (rows[i].wr)
				xfer(1'b1, rows[i].wa, 32'(rows[i].wd));
			rd(rows[i].ra, rows[i].ex);
		end
		settle();
		chk(32'({c_oe, c_out & c_oe}), 32'hf030);
		chk(32'({d_oe, d_out & d_oe}), 32'hcc48);
		rd(12'h000, 8'h36);
		rd(12'h00c, 8'h4b);
		xfer(1'b1, 12'h008, 32'h1f);
		xfer(1'b1, 12'h014, 32'h0);
		// Two-wire, serial out, async transmit, pwm b
		periph <= 17'h1f224;
		settle();
		chk(32'({c_oe[6:4], c_out[6:4]}), 32'h3e);
		chk(32'(d_out[5] & d_oe[5]), 32'h1);
		xfer(1'b1, 12'h018, 32'h17);
		settle();
		chk(32'(d_oe), 32'h20);
		chk(32'({fromio.parallel_slave_port, fromio.par_slave_data_in}), 32'h1e3);
		periph <= 17'h1f264;
		settle();
		chk(32'(d_oe), 32'hff);
		chk(32'({fromio.parallel_slave_port, fromio.par_slave_data_in}), 32'h0);
		// Synchronous master clock and data drive
		periph <= 17'h1ff80;
		settle();
		chk(32'({c_oe[7:6], c_out[7:6]}), 32'hf);
		chk(32'(fromio.capture2_in), 32'h1);
		cap_sel <= 1'b0;
		settle();
		chk(32'(fromio.capture2_in), 32'h0);
		// Sync slave: clock and data come in, port lets go of bits 6 and 7
		periph <= 17'h1f800;
		xfer(1'b1, 12'h008, 32'hff);
		settle();
		chk(32'({c_oe[7:6], fromio.sync_serial_clk}), 32'h1);
		chk(32'({fromio.uart_rx, fromio.sync_serial_data}), 32'h3);
		// Reset in mid-run floats every pin again
		periph <= '0;
		rst_n  <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(32'({c_oe, d_oe}), 32'h0);
		rd(12'h008, 8'hff);
		rd(12'h014, 8'hff);
		final_report();
	end
endmodule : tb_top
